// ---- hdl/bccb_bank.v ----
// Purpose: Upper chip control word of the bridge and the behaviour it steers
// Assumes: Config accesses arrive as single-cycle strobes from the config decoder
// Notes: Lower 15 bits of the control word belong elsewhere and read as zero here
// Functional notes
// (R1) Credit updates go out every two freed credits when bit 15 is clear, every one when set.
// (R2) Bit 16 sets when the retry counter expires and stays until reset or a write of one.
// (R3) Bits 18:17 pick the retry limit: none, 256, 64K or 2G retries.
// (R4) Bit 19 set disables the discard timer, clear leaves it to the bridge control register.
// (R5) Bit 20 set makes the discard timer expire after 64 PCI clocks.
// (R6) Bits 22:21 pick a configuration retry timeout of 25us, 0.5ms, 5ms or 25ms.
// (R7) Bit 23 set forces delayed transactions to complete in order.
// (R8) Bits 25:24 pick a completion timeout of 50us, 10ms, 50ms or none.
// (R9) Bit 26 clear maps forwarded PCI memory traffic to TC0, set uses the iso class.
// (R10) Bits 29:27 hold the isochronous traffic class, reset 001.
// (R11) Bit 30 set gates the internal clocks while the link is in L1 or L1s.
// (R12) Bit 31 set locks out primary-side config access with CRS completions.
// (R13) The retry counter counts consecutive retries on one transaction and restarts on completion.
`timescale 1ns/1ps
`include "bccb_defs.vh"

module bccb_bank #(
    parameter CRS_T0 = `BCCB_CRS_T0_NS / `BCCB_CLK_PERIOD_NS,
    parameter CRS_T1 = `BCCB_CRS_T1_NS / `BCCB_CLK_PERIOD_NS,
    parameter CRS_T2 = `BCCB_CRS_T2_NS / `BCCB_CLK_PERIOD_NS,
    parameter CRS_T3 = `BCCB_CRS_T3_NS / `BCCB_CLK_PERIOD_NS,
    parameter CPL_T0 = `BCCB_CPL_T0_NS / `BCCB_CLK_PERIOD_NS,
    parameter CPL_T1 = `BCCB_CPL_T1_NS / `BCCB_CLK_PERIOD_NS,
    parameter CPL_T2 = `BCCB_CPL_T2_NS / `BCCB_CLK_PERIOD_NS
) (
    input wire core_clk, // Clock, 100 MHz
    input wire srst, // Synchronous reset, active high
    input wire cfg_req, // Config access strobe
    input wire cfg_wr, // 1 write, 0 read
    input wire cfg_primary, // Access came from the primary side
    input wire [7:0] cfg_addr, // Byte offset
    input wire [3:0] cfg_be, // Byte enables
    input wire [31:0] cfg_wdata, // Write data
    output reg cfg_ack, // Access done, read data valid
    output reg cfg_crs, // Completion with CRS status
    output reg [31:0] cfg_rdata, // Read data
    input wire credit_freed, // One receive credit became free
    output reg fc_update, // Send flow-control update pulse
    input wire pci_retry, // Forwarded transaction got a retry
    input wire pci_done, // Forwarded transaction completed
    output reg retry_expired, // Retry limit reached, abandon
    input wire brg_disc_en, // Discard timer enable from bridge control
    input wire brg_disc_long, // Long discard duration from bridge control
    output reg disc_enable, // Discard timer runs
    output reg [9:0] disc_clks, // Discard timer length in PCI clocks
    input wire crs_start, // Config request retry timer start
    input wire crs_stop, // Config request retry timer stop
    output reg crs_timeout, // Config request retry timeout
    input wire cpl_start, // Completion timer start
    input wire cpl_stop, // Completion received
    output reg cpl_timeout, // Completion timeout
    output reg dt_in_order, // Delayed transactions strictly in order
    output reg [2:0] tx_tc, // Traffic class of forwarded memory writes
    input wire link_l1, // Link is in L1 or L1s
    output reg clk_gate // Gate internal clocks
);

localparam [9:0] DISC_LONG = 10'h200;
localparam [9:0] DISC_NORM = 10'h040;

reg fc_one_r;
reg retry_exp_r;
reg [1:0] retry_lim_r;
reg disc_dis_r;
reg disc_short_r;
reg [1:0] crs_sel_r;
reg dt_order_r;
reg [1:0] cpl_sel_r;
reg iso_en_r;
reg [2:0] iso_tc_r;
reg pwr_save_r;
reg pri_lock_r;
reg credit_half_r;
reg [31:0] retry_cnt_r;
reg [31:0] retry_lim_val;
reg [31:0] crs_lim;
reg [31:0] cpl_lim;
reg [31:0] ctrl_word;
wire crs_exp;
wire cpl_exp;
wire hit_ctrl;
wire wr_ok;
wire lim_hit;

function [31:0] sel4;
    input [1:0] s;
    input [31:0] a0;
    input [31:0] a1;
    input [31:0] a2;
    input [31:0] a3;
    begin
        case (s)
            2'h0: sel4 = a0;
            2'h1: sel4 = a1;
            2'h2: sel4 = a2;
            default: sel4 = a3;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Register access

assign hit_ctrl = (cfg_addr == `BCCB_OFS_CTRL);
assign wr_ok = cfg_req && cfg_wr && hit_ctrl && !(pri_lock_r && cfg_primary);

always @* begin
    ctrl_word = 32'h00000000;
    ctrl_word[`BCCB_BIT_FC_ONE] = fc_one_r;
    ctrl_word[`BCCB_BIT_RETRY_EXP] = retry_exp_r;
    ctrl_word[`BCCB_LSB_RETRY_LIM +: 2] = retry_lim_r;
    ctrl_word[`BCCB_BIT_DISC_DIS] = disc_dis_r;
    ctrl_word[`BCCB_BIT_DISC_SHORT] = disc_short_r;
    ctrl_word[`BCCB_LSB_CRS_TMR +: 2] = crs_sel_r;
    ctrl_word[`BCCB_BIT_DT_ORDER] = dt_order_r;
    ctrl_word[`BCCB_LSB_CPL_TMR +: 2] = cpl_sel_r;
    ctrl_word[`BCCB_BIT_ISO_EN] = iso_en_r;
    ctrl_word[`BCCB_LSB_ISO_TC +: 3] = iso_tc_r;
    ctrl_word[`BCCB_BIT_PWR_SAVE] = pwr_save_r;
    ctrl_word[`BCCB_BIT_PRI_LOCK] = pri_lock_r;
end

always @(posedge core_clk) begin
    if (srst) begin
        cfg_ack <= 1'b0;
        cfg_crs <= 1'b0;
        cfg_rdata <= 32'h00000000;
    end else begin
        cfg_ack <= cfg_req;
        cfg_crs <= cfg_req && pri_lock_r && cfg_primary; // R12
        if (cfg_req && !cfg_wr && hit_ctrl && !(pri_lock_r && cfg_primary)) begin
            cfg_rdata <= ctrl_word;
        end else begin
            cfg_rdata <= `BCCB_RST_RSVD;
        end
    end
end

always @(posedge core_clk) begin
    if (srst) begin
        fc_one_r <= 1'b0;
        retry_lim_r <= `BCCB_RST_RETRY_LIM;
        disc_dis_r <= 1'b0;
        disc_short_r <= 1'b0;
        crs_sel_r <= `BCCB_RST_CRS_TMR;
        dt_order_r <= 1'b0;
        cpl_sel_r <= `BCCB_RST_CPL_TMR;
        iso_en_r <= 1'b0;
        iso_tc_r <= `BCCB_RST_ISO_TC;
        pwr_save_r <= 1'b0;
        pri_lock_r <= 1'b0;
    end else if (wr_ok) begin
        if (cfg_be[1]) begin
            fc_one_r <= cfg_wdata[`BCCB_BIT_FC_ONE];
        end
        if (cfg_be[2]) begin
            retry_lim_r <= cfg_wdata[`BCCB_LSB_RETRY_LIM +: 2];
            disc_dis_r <= cfg_wdata[`BCCB_BIT_DISC_DIS];
            disc_short_r <= cfg_wdata[`BCCB_BIT_DISC_SHORT];
            crs_sel_r <= cfg_wdata[`BCCB_LSB_CRS_TMR +: 2];
            dt_order_r <= cfg_wdata[`BCCB_BIT_DT_ORDER];
        end
        if (cfg_be[3]) begin
            cpl_sel_r <= cfg_wdata[`BCCB_LSB_CPL_TMR +: 2];
            iso_en_r <= cfg_wdata[`BCCB_BIT_ISO_EN];
            iso_tc_r <= cfg_wdata[`BCCB_LSB_ISO_TC +: 3];
            pwr_save_r <= cfg_wdata[`BCCB_BIT_PWR_SAVE];
            pri_lock_r <= cfg_wdata[`BCCB_BIT_PRI_LOCK];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Flow-control credit updates

always @(posedge core_clk) begin
    if (srst) begin
        credit_half_r <= 1'b0;
        fc_update <= 1'b0;
    end else if (credit_freed) begin
        if (fc_one_r) begin
            credit_half_r <= 1'b0; // R1
            fc_update <= 1'b1; // R1
        end else begin
            credit_half_r <= !credit_half_r; // R1
            fc_update <= credit_half_r; // R1
        end
    end else begin
        fc_update <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// PCI retry counter

always @* begin
    retry_lim_val = sel4(retry_lim_r, 32'h00000000, `BCCB_RETRY_LIM_256,
        `BCCB_RETRY_LIM_64K, `BCCB_RETRY_LIM_2G); // R3
end

assign lim_hit = (retry_lim_r != 2'h0) && (retry_cnt_r + 32'h00000001 >= retry_lim_val); // R3

always @(posedge core_clk) begin
    if (srst) begin
        retry_cnt_r <= 32'h00000000;
        retry_expired <= 1'b0;
        retry_exp_r <= 1'b0;
    end else begin
        retry_expired <= 1'b0;
        if (pci_done) begin
            retry_cnt_r <= 32'h00000000; // R13
        end else if (pci_retry) begin
            if (lim_hit) begin
                retry_cnt_r <= 32'h00000000; // R13
                retry_expired <= 1'b1;
            end else begin
                retry_cnt_r <= retry_cnt_r + 32'h00000001; // R13
            end
        end
        if (pci_retry && !pci_done && lim_hit) begin
            retry_exp_r <= 1'b1; // R2
        end else if (wr_ok && cfg_be[2] && cfg_wdata[`BCCB_BIT_RETRY_EXP]) begin
            retry_exp_r <= 1'b0; // R2
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Discard timer, ordering, traffic class, power saving

always @(posedge core_clk) begin
    if (srst) begin
        disc_enable <= 1'b0;
        disc_clks <= DISC_NORM;
        dt_in_order <= 1'b0;
        tx_tc <= 3'h0;
        clk_gate <= 1'b0;
    end else begin
        disc_enable <= brg_disc_en && !disc_dis_r; // R4
        if (disc_short_r) begin
            disc_clks <= `BCCB_DISC_SHORT_CLKS; // R5
        end else begin
            disc_clks <= brg_disc_long ? DISC_LONG : DISC_NORM; // R5
        end
        dt_in_order <= dt_order_r; // R7
        tx_tc <= iso_en_r ? iso_tc_r : 3'h0; // R9 R10
        clk_gate <= pwr_save_r && link_l1; // R11
    end
end

////////////////////////////////////////////////////////////////////////////////
// Configuration retry and completion timers

always @* begin
    crs_lim = sel4(crs_sel_r, CRS_T0, CRS_T1, CRS_T2, CRS_T3); // R6
    cpl_lim = sel4(cpl_sel_r, CPL_T0, CPL_T1, CPL_T2, 32'h00000000); // R8
end

bccb_timer #(.W(32)) u_crs_tmr (
    .core_clk(core_clk),
    .srst(srst),
    .start(crs_start),
    .stop(crs_stop),
    .limit(crs_lim),
    .expired(crs_exp)
);

bccb_timer #(.W(32)) u_cpl_tmr (
    .core_clk(core_clk),
    .srst(srst),
    .start(cpl_start),
    .stop(cpl_stop),
    .limit(cpl_lim),
    .expired(cpl_exp)
);

always @(posedge core_clk) begin
    if (srst) begin
        crs_timeout <= 1'b0;
        cpl_timeout <= 1'b0;
    end else begin
        crs_timeout <= crs_exp; // R6
        cpl_timeout <= cpl_exp && (cpl_sel_r != 2'h3); // R8
    end
end

endmodule

// ---- hdl/bccb_defs.vh ----
// Purpose: Offsets, field positions, reset values and timing counts for the chip control bank
// Assumes: core_clk at 100 MHz (10 ns period)
// Notes: Definitions only
`ifndef BCCB_DEFS_VH
`define BCCB_DEFS_VH

`define BCCB_OFS_CTRL 8'h40
`define BCCB_OFS_RSVD 8'h44

`define BCCB_BIT_FC_ONE 15
`define BCCB_BIT_RETRY_EXP 16
`define BCCB_LSB_RETRY_LIM 17
`define BCCB_BIT_DISC_DIS 19
`define BCCB_BIT_DISC_SHORT 20
`define BCCB_LSB_CRS_TMR 21
`define BCCB_BIT_DT_ORDER 23
`define BCCB_LSB_CPL_TMR 24
`define BCCB_BIT_ISO_EN 26
`define BCCB_LSB_ISO_TC 27
`define BCCB_BIT_PWR_SAVE 30
`define BCCB_BIT_PRI_LOCK 31

`define BCCB_RST_RETRY_LIM 2'h0
`define BCCB_RST_CRS_TMR 2'h1
`define BCCB_RST_CPL_TMR 2'h1
`define BCCB_RST_ISO_TC 3'h1
`define BCCB_RST_RSVD 32'h00000000

`define BCCB_CLK_PERIOD_NS 10
`define BCCB_RETRY_LIM_256 32'h00000100
`define BCCB_RETRY_LIM_64K 32'h00010000
`define BCCB_RETRY_LIM_2G 32'h80000000
`define BCCB_DISC_SHORT_CLKS 10'h040
`define BCCB_CRS_T0_NS 25000
`define BCCB_CRS_T1_NS 500000
`define BCCB_CRS_T2_NS 5000000
`define BCCB_CRS_T3_NS 25000000
`define BCCB_CPL_T0_NS 50000
`define BCCB_CPL_T1_NS 10000000
`define BCCB_CPL_T2_NS 50000000

`endif

// ---- hdl/bccb_timer.v ----
// Purpose: One-shot expiry timer with a run-time limit
// Assumes: Limit stays stable while the count runs; it is compared every running cycle
// Notes: Expired stays high until the next start or stop
`timescale 1ns/1ps

module bccb_timer #(
    parameter W = 32
) (
    input wire core_clk, // Clock
    input wire srst, // Synchronous reset
    input wire start, // Start counting from zero
    input wire stop, // Abandon count
    input wire [W-1:0] limit, // Cycles to expiry
    output reg expired // Count reached limit
);

reg [W-1:0] cnt_r;
reg run_r;

always @(posedge core_clk) begin
    if (srst) begin
        cnt_r <= {W{1'b0}};
        run_r <= 1'b0;
        expired <= 1'b0;
    end else if (start) begin
        cnt_r <= {W{1'b0}};
        run_r <= 1'b1;
        expired <= 1'b0;
    end else if (stop) begin
        run_r <= 1'b0;
        expired <= 1'b0;
    end else if (run_r) begin
        if (cnt_r + 1'b1 >= limit) begin
            run_r <= 1'b0;
            expired <= 1'b1;
        end
        cnt_r <= cnt_r + 1'b1;
    end
end

endmodule

// ---- verif/bccb_asserts.sv ----
// Purpose: Port-level checks for the chip control bank
// Assumes: One clock, synchronous active-high reset
// Notes: Bound into every bccb_bank instance
`timescale 1ns/1ps

module bccb_asserts (
    input wire core_clk, // Clock
    input wire srst, // Reset
    input wire cfg_req, // Access strobe
    input wire cfg_ack, // Access done
    input wire cfg_crs, // CRS completion
    input wire [31:0] cfg_rdata, // Read data
    input wire credit_freed, // Freed credit
    input wire fc_update, // Credit update
    input wire pci_retry, // Retry termination
    input wire retry_expired, // Retry limit hit
    input wire brg_disc_en, // Bridge discard enable
    input wire brg_disc_long, // Bridge long discard
    input wire disc_enable, // Discard timer runs
    input wire [9:0] disc_clks, // Discard length
    input wire crs_stop, // Retry timer stop
    input wire crs_timeout, // Retry timer expiry
    input wire cpl_stop, // Completion timer stop
    input wire cpl_timeout, // Completion timer expiry
    input wire link_l1, // Link in L1
    input wire clk_gate // Clock gate
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    a_ack_follows_req: assert property (cfg_req |=> cfg_ack)
        else $error("no ack after access");
    a_ack_needs_req: assert property (!cfg_req |=> !cfg_ack)
        else $error("ack without access");
    a_crs_empty_data: assert property (cfg_crs |-> cfg_ack && cfg_rdata == 32'h00000000)
        else $error("crs completion malformed");
    a_fc_has_credit: assert property (fc_update |-> $past(credit_freed))
        else $error("credit update without freed credit");
    a_expiry_has_retry: assert property (retry_expired |-> $past(pci_retry))
        else $error("retry expiry without retry");
    a_disc_bridge_off: assert property (!brg_disc_en |=> !disc_enable)
        else $error("discard timer runs while bridge disables it");
    a_disc_short_len: assert property (!brg_disc_long |=> disc_clks == 10'h040)
        else $error("discard length not 64");
    a_crs_stop_clears: assert property (crs_stop |=> ##1 !crs_timeout)
        else $error("retry timeout stays after stop");
    a_cpl_stop_clears: assert property (cpl_stop |=> ##1 !cpl_timeout)
        else $error("completion timeout stays after stop");
    a_gate_needs_l1: assert property (!link_l1 |=> !clk_gate)
        else $error("clocks gated outside L1");
endmodule

bind bccb_bank bccb_asserts u_chk (.core_clk, .srst, .cfg_req, .cfg_ack, .cfg_crs, .cfg_rdata,
    .credit_freed, .fc_update, .pci_retry, .retry_expired, .brg_disc_en, .brg_disc_long,
    .disc_enable, .disc_clks, .crs_stop, .crs_timeout, .cpl_stop, .cpl_timeout, .link_l1,
    .clk_gate);

// ---- verif/bccb_far.sv ----
// Purpose: Link and PCI side events seen by the bank
// Assumes: Pulses change at the falling edge
// Notes: Tasks are called by the bench
`timescale 1ns/1ps

module bccb_far (
    input wire core_clk, // Clock
    output logic credit_freed, // Freed credit pulse
    output logic pci_retry, // Retry termination pulse
    output logic pci_done // Transaction completion pulse
);
    initial begin
        credit_freed = 1'b0;
        pci_retry = 1'b0;
        pci_done = 1'b0;
    end

    task automatic credits(input int n);
        repeat (n) begin
            @(negedge core_clk) credit_freed = 1'b1;
            @(negedge core_clk) credit_freed = 1'b0;
        end
    endtask

    task automatic retries(input int n);
        repeat (n) begin
            @(negedge core_clk) pci_retry = 1'b1;
            @(negedge core_clk) pci_retry = 1'b0;
        end
    endtask

    task automatic finish_xfer;
        @(negedge core_clk) pci_done = 1'b1;
        @(negedge core_clk) pci_done = 1'b0;
    endtask
endmodule

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the chip control bank
// Assumes: Short retry timer limits 10, 20, 30, 40 cycles; completion timer limits 10, 20, 30 cycles
// Notes: Inputs change at the falling edge
`timescale 1ns/1ps

module tb_top;
    logic core_clk = 1'b0, srst = 1'b1, cfg_req = 1'b0, cfg_wr = 1'b0, cfg_primary = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'hF;
    logic [31:0] cfg_wdata = 32'h00000000, rd;
    logic cfg_ack, cfg_crs, crs, fc_update, retry_expired, disc_enable, crs_timeout, cpl_timeout;
    logic [31:0] cfg_rdata;
    logic credit_freed, pci_retry, pci_done, dt_in_order, clk_gate;
    logic brg_disc_en = 1'b1, brg_disc_long = 1'b1, link_l1 = 1'b1;
    logic crs_start = 1'b0, crs_stop = 1'b0, cpl_start = 1'b0, cpl_stop = 1'b0;
    logic [9:0] disc_clks;
    logic [2:0] tx_tc;
    int mismatches = 0, checks = 0, nfc = 0, nexp = 0, cyc = 0;

    always #5 core_clk = ~core_clk;

    bccb_far u_far (.core_clk(core_clk), .credit_freed(credit_freed), .pci_retry(pci_retry),
        .pci_done(pci_done));

    bccb_bank #(.CRS_T0(10), .CRS_T1(20), .CRS_T2(30), .CRS_T3(40), .CPL_T0(10), .CPL_T1(20),
        .CPL_T2(30)) u_dut (.core_clk(core_clk), .srst(srst), .cfg_req(cfg_req),
        .cfg_wr(cfg_wr), .cfg_primary(cfg_primary), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_crs(cfg_crs), .cfg_rdata(cfg_rdata),
        .credit_freed(credit_freed), .fc_update(fc_update), .pci_retry(pci_retry),
        .pci_done(pci_done), .retry_expired(retry_expired), .brg_disc_en(brg_disc_en),
        .brg_disc_long(brg_disc_long), .disc_enable(disc_enable), .disc_clks(disc_clks),
        .crs_start(crs_start), .crs_stop(crs_stop), .crs_timeout(crs_timeout),
        .cpl_start(cpl_start), .cpl_stop(cpl_stop), .cpl_timeout(cpl_timeout),
        .dt_in_order(dt_in_order), .tx_tc(tx_tc), .link_l1(link_l1), .clk_gate(clk_gate));

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (fc_update === 1'b1) nfc <= nfc + 1;
        if (retry_expired === 1'b1) nexp <= nexp + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            complete_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask

    // One access; ack, CRS and data are sampled in the answer cycle
    task automatic cfg(input logic w, input logic p, input logic [7:0] a, input logic [31:0] d);
        @(negedge core_clk);
        {cfg_req, cfg_wr, cfg_primary, cfg_addr, cfg_wdata} = {1'b1, w, p, a, d};
        @(negedge core_clk) cfg_req = 1'b0;
        chk(cfg_ack, 1'b1);
        rd = cfg_rdata;
        crs = cfg_crs;
    endtask

    task automatic tmr(input logic c, input int lim, input logic e);
        @(negedge core_clk) {crs_start, cpl_start} = {c, !c};
        @(negedge core_clk) {crs_start, cpl_start} = 2'b00;
        repeat (lim) @(negedge core_clk);
        chk(c ? crs_timeout : cpl_timeout, 1'b0);
        @(negedge core_clk);
        chk(c ? crs_timeout : cpl_timeout, e);
        {crs_stop, cpl_stop} = 2'b11;
        @(negedge core_clk) {crs_stop, cpl_stop} = 2'b00;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        cfg(0, 0, 8'h40, 0); chk(rd, 32'h09200000);
        chk(tx_tc, 3'h0);
        cfg(0, 0, 8'h44, 0); chk(rd, 32'h00000000);
        cfg(0, 0, 8'h48, 0); chk(rd, 32'h00000000);
        $display("reset test done");
    endtask

    task automatic t_ctrl;
        cfg(1, 0, 8'h40, 32'hFFF80000);
        cfg(0, 0, 8'h40, 0); chk(rd, 32'hFFF80000);
        chk({dt_in_order, tx_tc, disc_enable, clk_gate}, 6'h3D);
        chk(disc_clks, 10'h040);
        link_l1 = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(clk_gate, 1'b0);
        link_l1 = 1'b1;
        cfg(0, 1, 8'h40, 0);
        chk(crs, 1'b1);
        chk(rd, 32'h00000000);
        cfg(1, 1, 8'h40, 0); chk(crs, 1'b1);
        cfg(0, 0, 8'h40, 0);
        chk(crs, 1'b0);
        chk(rd, 32'hFFF80000);
        cfg(1, 0, 8'h40, 32'h38000000);
        cfg(0, 1, 8'h40, 0);
        chk(crs, 1'b0);
        chk(rd, 32'h38000000);
        chk({dt_in_order, tx_tc, disc_enable, clk_gate}, 6'h02);
        chk(disc_clks, 10'h200);
        {brg_disc_en, brg_disc_long} = 2'b00;
        repeat (2) @(negedge core_clk);
        chk({disc_enable, disc_clks}, {1'b0, 10'h040});
        {brg_disc_en, brg_disc_long} = 2'b11;
        // Only byte 2 may land
        cfg_be = 4'h4;
        cfg(1, 0, 8'h40, 32'hFFFFFFFF);
        cfg_be = 4'hF;
        cfg(0, 0, 8'h40, 0); chk(rd, 32'h38FE0000);
        chk({disc_enable, disc_clks}, {1'b0, 10'h040});
        $display("control test done");
    endtask

    task automatic t_fc;
        cfg(1, 0, 8'h40, 0);
        nfc = 0;
        u_far.credits(4);
        repeat (2) @(negedge core_clk);
        chk(nfc, 2);
        cfg(1, 0, 8'h40, 32'h00008000);
        u_far.credits(3);
        repeat (2) @(negedge core_clk);
        chk(nfc, 5);
        $display("credit test done");
    endtask

    task automatic t_retry;
        cfg(1, 0, 8'h40, 32'h00020000);
        nexp = 0;
        u_far.retries(255);
        u_far.finish_xfer;
        u_far.retries(255);
        repeat (2) @(negedge core_clk);
        chk(nexp, 0);
        u_far.retries(1);
        repeat (2) @(negedge core_clk);
        chk(nexp, 1);
        cfg(0, 0, 8'h40, 0); chk(rd, 32'h00030000);
        cfg(1, 0, 8'h40, 32'h00030000);
        cfg(0, 0, 8'h40, 0); chk(rd, 32'h00020000);
        $display("retry test done");
    endtask

    task automatic t_timers;
        for (int i = 0; i < 4; i++) begin
            cfg(1, 0, 8'h40, (i << 21) | (i << 24));
            tmr(1'b1, 10 * (i + 1), 1'b1);
            tmr(1'b0, 10 * (i + 1), i != 3);
        end
        $display("timer test done");
    endtask

    task automatic t_midreset;
        srst = 1'b1;
        repeat (2) @(negedge core_clk);
        srst = 1'b0;
        t_reset;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge core_clk);
        srst = 1'b0;
        t_reset;
        t_ctrl;
        t_fc;
        t_retry;
        t_timers;
        t_midreset;
        complete_run;
    end
endmodule
